// ==== tsens_port.sv ====
// Serial command port of the temperature sensor, target side
`timescale 1ns/1ps
module tsens_port
    import tsens_pkg::*;
#(
    parameter int PU_CYC = POWERUP_CYC,
    parameter int M_LOW_CYC = MEAS_LOW_CYC,
    parameter int M_MED_CYC = MEAS_MED_CYC,
    parameter int M_HIGH_CYC = MEAS_HIGH_CYC
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic addr_sel,
    input wire logic pin_reset_low,
    input wire logic alert_cond,
    output logic alert,
    input wire logic [15:0] temp_in,
    output logic meas_start,
    output logic [1:0] meas_rep,
    output logic meas_busy,
    output logic idle,
    output logic wr_valid,
    output logic [15:0] wr_cmd,
    output logic [15:0] wr_data
);
    pins_if p ();

    pin_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .addr_sel(addr_sel),
        .pin_reset_low(pin_reset_low),
        .pins(p)
    );

    // ****************************************************
    // Power-up wait
    // ****************************************************
    logic [CNT_W-1:0] pu_cnt_r, pu_cnt_nxt;
    logic ready_r, ready_nxt;

    always_comb
    begin
        pu_cnt_nxt = pu_cnt_r;
        ready_nxt = ready_r;
        if (p.rst_low)
        begin
            pu_cnt_nxt = '0;
            ready_nxt = 1'b0;
        end
        else if (!ready_r)
        begin
            pu_cnt_nxt = pu_cnt_r + 1'b1;
            if (pu_cnt_r == CNT_W'(PU_CYC - 1))
                ready_nxt = 1'b1;
        end
    end

    // ****************************************************
    // Protocol state
    // ****************************************************
    port_state_t st_r, st_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic rw_r, rw_nxt;
    logic ack_r, ack_nxt;
    logic mack_r, mack_nxt;
    logic [15:0] cmd_r, cmd_nxt;
    logic [15:0] dat_r, dat_nxt;
    logic wrv_r, wrv_nxt;
    logic go, clr;
    logic [3:0] cmd_chk;
    logic busy_r, valid_r, stretch_r;
    logic [15:0] temp_r;

    // Check bits are embedded: only listed words pass
    always_comb
    begin
        cmd_chk = 4'h0;
        if (cmd_r[15:8] == CMD_MSB_STRETCH)
        begin
            case (sh_r)
                CMD_S_HIGH: cmd_chk = {2'b11, REP_HIGH};
                CMD_S_MED: cmd_chk = {2'b11, REP_MED};
                CMD_S_LOW: cmd_chk = {2'b11, REP_LOW};
                default: cmd_chk = 4'h0;
            endcase
        end
        else if (cmd_r[15:8] == CMD_MSB_NOSTRETCH)
        begin
            case (sh_r)
                CMD_N_HIGH: cmd_chk = {2'b10, REP_HIGH};
                CMD_N_MED: cmd_chk = {2'b10, REP_MED};
                CMD_N_LOW: cmd_chk = {2'b10, REP_LOW};
                default: cmd_chk = 4'h0;
            endcase
        end
    end

    function automatic logic [7:0] rd_byte(input logic [2:0] i,
        input logic [15:0] t);
        case (i)
            3'd1: rd_byte = t[15:8];
            3'd2: rd_byte = t[7:0];
            default: rd_byte = crc8(t);
        endcase
    endfunction : rd_byte

    always_comb
    begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        idx_nxt = idx_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        addr_nxt = addr_r;
        rw_nxt = rw_r;
        ack_nxt = ack_r;
        mack_nxt = mack_r;
        cmd_nxt = cmd_r;
        dat_nxt = dat_r;
        wrv_nxt = 1'b0;
        go = 1'b0;
        clr = 1'b0;
        if (!ready_r || p.rst_low)
            st_nxt = ST_IDLE;
        else if (p.start)
        begin
            st_nxt = ST_HDR;
            bit_nxt = 4'h0;
            idx_nxt = 3'd0;
            ack_nxt = 1'b0;
            addr_nxt = p.addr ? ADDR_HIGH : ADDR_LOW;
        end
        else if (p.stop)
            st_nxt = ST_IDLE;
        else
        begin
            case (st_r)
                ST_HDR, ST_WBYTE:
                begin
                    if (p.scl_rise && bit_r != BITS_PER_BYTE)
                    begin
                        sh_nxt = {sh_r[6:0], p.sda};
                        bit_nxt = bit_r + 1'b1;
                    end
                    else if (p.scl_fall && bit_r == BITS_PER_BYTE)
                    begin
                        bit_nxt = 4'h0;
                        st_nxt = ST_WACK;
                        ack_nxt = 1'b1;
                        if (st_r == ST_HDR)
                        begin
                            rw_nxt = sh_r[0];
                            if (sh_r[7:1] != addr_r)
                            begin
                                st_nxt = ST_IGNORE;
                                ack_nxt = 1'b0;
                            end
                            else if (sh_r[0] && !valid_r &&
                                !(busy_r && stretch_r))
                                ack_nxt = 1'b0;
                        end
                        else
                        begin
                            case (idx_r)
                                3'd1: cmd_nxt[15:8] = sh_r;
                                3'd2:
                                begin
                                    cmd_nxt[7:0] = sh_r;
                                    go = cmd_chk[3];
                                    ack_nxt = cmd_chk[3];
                                end
                                3'd3: dat_nxt[15:8] = sh_r;
                                3'd4: dat_nxt[7:0] = sh_r;
                                3'd5: wrv_nxt = (crc8(dat_r) == sh_r);
                                default: ack_nxt = 1'b0;
                            endcase
                        end
                    end
                end
                ST_WACK:
                begin
                    if (p.scl_fall)
                    begin
                        idx_nxt = idx_r + 1'b1;
                        ack_nxt = 1'b0;
                        if (!ack_r)
                            st_nxt = ST_IGNORE;
                        else if (!rw_r)
                            st_nxt = ST_WBYTE;
                        else if (valid_r)
                        begin
                            st_nxt = ST_RBYTE;
                            tx_nxt = rd_byte(3'd1, temp_r);
                        end
                        else
                            st_nxt = ST_STRETCH;
                    end
                end
                ST_STRETCH:
                begin
                    if (valid_r)
                    begin
                        st_nxt = ST_RBYTE;
                        tx_nxt = rd_byte(3'd1, temp_r);
                    end
                    else if (!busy_r)
                        st_nxt = ST_IGNORE;
                end
                ST_RBYTE:
                begin
                    if (p.scl_rise)
                        bit_nxt = bit_r + 1'b1;
                    else if (p.scl_fall)
                    begin
                        if (bit_r == BITS_PER_BYTE)
                        begin
                            bit_nxt = 4'h0;
                            st_nxt = ST_RACK;
                        end
                        else
                            tx_nxt = {tx_r[6:0], 1'b1};
                    end
                end
                ST_RACK:
                begin
                    if (p.scl_rise)
                        mack_nxt = ~p.sda;
                    else if (p.scl_fall)
                    begin
                        idx_nxt = idx_r + 1'b1;
                        if (idx_r == 3'd3)
                            clr = 1'b1;
                        if (mack_r && idx_r < 3'd3)
                        begin
                            st_nxt = ST_RBYTE;
                            tx_nxt = rd_byte(idx_r + 1'b1, temp_r);
                        end
                        else
                            st_nxt = ST_IGNORE;
                    end
                end
                ST_IDLE, ST_IGNORE: st_nxt = st_r;
                default: st_nxt = ST_IDLE;
            endcase
        end
    end

    // ****************************************************
    // Measurement timer
    // ****************************************************
    logic [CNT_W-1:0] mcnt_r, mcnt_nxt;
    logic busy_nxt, valid_nxt, stretch_nxt;
    logic [15:0] temp_nxt;
    logic [1:0] rep_r, rep_nxt;
    logic mstart_r;

    always_comb
    begin
        mcnt_nxt = mcnt_r;
        busy_nxt = busy_r;
        valid_nxt = valid_r;
        stretch_nxt = stretch_r;
        temp_nxt = temp_r;
        rep_nxt = rep_r;
        if (p.rst_low)
        begin
            busy_nxt = 1'b0;
            valid_nxt = 1'b0;
        end
        else if (go)
        begin
            busy_nxt = 1'b1;
            valid_nxt = 1'b0;
            stretch_nxt = cmd_chk[2];
            rep_nxt = cmd_chk[1:0];
            case (cmd_chk[1:0])
                REP_HIGH: mcnt_nxt = CNT_W'(M_HIGH_CYC);
                REP_MED: mcnt_nxt = CNT_W'(M_MED_CYC);
                default: mcnt_nxt = CNT_W'(M_LOW_CYC);
            endcase
        end
        else if (busy_r)
        begin
            mcnt_nxt = mcnt_r - 1'b1;
            if (mcnt_r == CNT_W'(1))
            begin
                busy_nxt = 1'b0;
                valid_nxt = 1'b1;
                temp_nxt = temp_in;
            end
        end
        else if (clr)
            valid_nxt = 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pu_cnt_r <= '0;
            ready_r <= 1'b0;
            st_r <= ST_IDLE;
            bit_r <= 4'h0;
            idx_r <= 3'd0;
            sh_r <= 8'h00;
            tx_r <= 8'hff;
            addr_r <= ADDR_LOW;
            rw_r <= 1'b0;
            ack_r <= 1'b0;
            mack_r <= 1'b0;
            cmd_r <= 16'h0000;
            dat_r <= 16'h0000;
            wrv_r <= 1'b0;
            mcnt_r <= '0;
            busy_r <= 1'b0;
            valid_r <= 1'b0;
            stretch_r <= 1'b0;
            temp_r <= 16'h0000;
            rep_r <= REP_LOW;
            mstart_r <= 1'b0;
            alert <= 1'b0;
        end
        else
        begin
            pu_cnt_r <= pu_cnt_nxt;
            ready_r <= ready_nxt;
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            idx_r <= idx_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            addr_r <= addr_nxt;
            rw_r <= rw_nxt;
            ack_r <= ack_nxt;
            mack_r <= mack_nxt;
            cmd_r <= cmd_nxt;
            dat_r <= dat_nxt;
            wrv_r <= wrv_nxt;
            mcnt_r <= mcnt_nxt;
            busy_r <= busy_nxt;
            valid_r <= valid_nxt;
            stretch_r <= stretch_nxt;
            temp_r <= temp_nxt;
            rep_r <= rep_nxt;
            mstart_r <= go;
            alert <= alert_cond;
        end
    end

    // ****************************************************
    // Pin drive and outputs
    // ****************************************************
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = (st_r == ST_STRETCH);
    assign sda_oe = ((st_r == ST_WACK) && ack_r) ||
        ((st_r == ST_RBYTE) && !tx_r[7]);
    assign meas_start = mstart_r;
    assign meas_rep = rep_r;
    assign meas_busy = busy_r;
    assign idle = ready_r && !busy_r && (st_r == ST_IDLE ||
        st_r == ST_IGNORE);
    assign wr_valid = wrv_r;
    assign wr_cmd = cmd_r;
    assign wr_data = dat_r;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_hdr_done;
        st_r == ST_HDR && p.scl_fall && bit_r == BITS_PER_BYTE;
    endsequence
    sequence s_byte_done;
        (st_r == ST_HDR || st_r == ST_WBYTE) && p.scl_fall &&
            bit_r == BITS_PER_BYTE && !p.start && !p.stop && ready_r &&
            !p.rst_low;
    endsequence

    property p_pull_only;
        !scl_o && !sda_o;
    endproperty
    a_pull_only: assert property (p_pull_only) else $error("pin high");

    property p_mismatch;
        s_hdr_done ##0 (sh_r[7:1] != addr_r) && !p.start && ready_r &&
            !p.rst_low |=> st_r == ST_IGNORE && !sda_oe;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("bad ack");

    property p_ack_slot;
        s_byte_done ##0 ack_nxt |=> sda_oe && st_r == ST_WACK;
    endproperty
    a_ack_slot: assert property (p_ack_slot) else $error("no ack");

    property p_addr_sel;
        p.start && ready_r && !p.rst_low |=>
            addr_r == ($past(p.addr) ? ADDR_HIGH : ADDR_LOW);
    endproperty
    a_addr_sel: assert property (p_addr_sel) else $error("addr");

    property p_meas_go;
        go |=> meas_start && busy_r && st_r == ST_WACK && sda_oe;
    endproperty
    a_meas_go: assert property (p_meas_go) else $error("no start");

    property p_meas_hold;
        meas_start && !p.rst_low |-> busy_r [*8];
    endproperty
    a_meas_hold: assert property (p_meas_hold) else $error("short");

    property p_not_ready;
        !ready_r |-> !sda_oe && !scl_oe && !go;
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("early");

    property p_alert;
        ##1 alert == $past(alert_cond);
    endproperty
    a_alert: assert property (p_alert) else $error("alert");

    property p_wr_crc;
        wr_valid |-> $past(crc8(dat_r)) == $past(sh_r);
    endproperty
    a_wr_crc: assert property (p_wr_crc) else $error("crc");

    property p_stretch;
        scl_oe |-> busy_r && stretch_r || valid_r;
    endproperty
    a_stretch: assert property (p_stretch) else $error("stretch");
endmodule : tsens_port

// ==== tsens_pkg.sv ====
// Shared constants, types and helpers for the sensor command port
package tsens_pkg;

    // ****************************************************
    // Bus addresses and command bytes
    // ****************************************************
    localparam logic [6:0] ADDR_LOW = 7'h4a;
    localparam logic [6:0] ADDR_HIGH = 7'h4b;
    localparam logic [7:0] CMD_MSB_STRETCH = 8'h2c;
    localparam logic [7:0] CMD_MSB_NOSTRETCH = 8'h24;
    localparam logic [7:0] CMD_S_HIGH = 8'h06;
    localparam logic [7:0] CMD_S_MED = 8'h0d;
    localparam logic [7:0] CMD_S_LOW = 8'h10;
    localparam logic [7:0] CMD_N_HIGH = 8'h00;
    localparam logic [7:0] CMD_N_MED = 8'h0b;
    localparam logic [7:0] CMD_N_LOW = 8'h16;
    localparam logic [1:0] REP_LOW = 2'h0;
    localparam logic [1:0] REP_MED = 2'h1;
    localparam logic [1:0] REP_HIGH = 2'h2;

    // ****************************************************
    // Checksum
    // ****************************************************
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hff;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int POWERUP_WAIT_TIME_NS = 1500000;
    localparam int MEAS_LOW_NS = 4500000;
    localparam int MEAS_MED_NS = 6500000;
    localparam int MEAS_HIGH_NS = 15500000;
    localparam int POWERUP_CYC = POWERUP_WAIT_TIME_NS / CLK_PERIOD_NS;
    localparam int MEAS_LOW_CYC = MEAS_LOW_NS / CLK_PERIOD_NS;
    localparam int MEAS_MED_CYC = MEAS_MED_NS / CLK_PERIOD_NS;
    localparam int MEAS_HIGH_CYC = MEAS_HIGH_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 21;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_HDR = 8'h02,
        ST_WBYTE = 8'h04,
        ST_WACK = 8'h08,
        ST_RBYTE = 8'h10,
        ST_RACK = 8'h20,
        ST_STRETCH = 8'h40,
        ST_IGNORE = 8'h80
    } port_state_t;

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--)
        begin
            if (c[7] ^ d[i])
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            else
                c = {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8

endpackage : tsens_pkg

// ==== pins_if.sv ====
// Synchronised pin levels and bus events passed to the port logic
`timescale 1ns/1ps
interface pins_if;
    logic scl;
    logic sda;
    logic addr;
    logic rst_low;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    modport src (output scl, sda, addr, rst_low, scl_rise, scl_fall,
        start, stop);
    modport dst (input scl, sda, addr, rst_low, scl_rise, scl_fall,
        start, stop);
endinterface : pins_if

// ==== pin_sync.sv ====
// Two-stage synchronisers and bus event detection for the pins
`timescale 1ns/1ps
module pin_sync
    import tsens_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic addr_sel,
    input wire logic pin_reset_low,
    pins_if.src pins
);
    logic [3:0] raw;
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic scl_d_r;
    logic sda_d_r;

    assign raw = {pin_reset_low, addr_sel, sda_i, scl_i};

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_sync
            always_ff @(posedge mclk)
            begin
                if (rst)
                begin
                    s1_r[g] <= 1'b1;
                    s2_r[g] <= 1'b1;
                end
                else
                begin
                    s1_r[g] <= raw[g];
                    s2_r[g] <= s1_r[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_d_r <= s2_r[0];
            sda_d_r <= s2_r[1];
        end
    end

    assign pins.scl = s2_r[0];
    assign pins.sda = s2_r[1];
    assign pins.addr = s2_r[2];
    assign pins.rst_low = ~s2_r[3];
    assign pins.scl_rise = s2_r[0] & ~scl_d_r;
    assign pins.scl_fall = ~s2_r[0] & scl_d_r;
    assign pins.start = s2_r[0] & scl_d_r & sda_d_r & ~s2_r[1];
    assign pins.stop = s2_r[0] & scl_d_r & ~sda_d_r & s2_r[1];
endmodule : pin_sync

// ==== i2c_master_model.sv ====
// Bus master model that frames bytes on the two wires
`timescale 1ns/1ps
module i2c_master_model
(
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    // ****
    // Wire tasks
    // ****
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic bit_x(input logic b, output logic r);
        int n;
        n = 0;
        #31.25 sda_low = !b;
        #31.25 scl_low = 1'b0;
        // Let the wire settle before testing for a stretch
        #1;
        while (scl !== 1'b1 && n < 3000)
        begin
            #8 n++;
        end
        #61.5 r = sda;
        scl_low = 1'b1;
    endtask : bit_x
    task automatic start();
        #62.5 sda_low = 1'b0;
        #31.25 scl_low = 1'b0;
        #31.25 sda_low = 1'b1;
        #31.25 scl_low = 1'b1;
    endtask : start
    task automatic stop();
        #31.25 sda_low = 1'b1;
        #31.25 scl_low = 1'b0;
        #31.25 sda_low = 1'b0;
    endtask : stop
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask : wbyte
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(nack, r);
    endtask : rbyte
endmodule : i2c_master_model

// ==== test_temp_sensor_i2c_cmd_port.sv ====
// Self-checking bench for the sensor command port
`timescale 1ns/1ps
module test_temp_sensor_i2c_cmd_port
    import tsens_pkg::*;
;
    localparam int PU = 20;
    localparam int ML = 400;
    localparam int MM = 500;
    localparam int MH = 600;
    localparam logic [7:0] WH = {ADDR_LOW, 1'b0};
    localparam logic [7:0] RH = {ADDR_LOW, 1'b1};
    logic mclk, rst, scl_o, scl_oe, sda_o, sda_oe, addr_sel, alert;
    logic pin_reset_low, alert_cond, meas_start, meas_busy, idle;
    logic wr_valid, m_scl_low, m_sda_low, scl_w, sda_w;
    logic [1:0] meas_rep;
    logic [15:0] temp_in, wr_cmd, wr_data;
    int err_count, num_checks, cyc, n_start, n_wr, n_drv, blen;
    assign scl_w = !(m_scl_low || scl_oe);
    assign sda_w = !(m_sda_low || sda_oe);
    tsens_port #(.PU_CYC(PU), .M_LOW_CYC(ML), .M_MED_CYC(MM),
        .M_HIGH_CYC(MH)) dut (.mclk(mclk), .rst(rst), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_sel(addr_sel), .alert(alert),
        .pin_reset_low(pin_reset_low), .alert_cond(alert_cond),
        .temp_in(temp_in), .meas_start(meas_start), .meas_rep(meas_rep),
        .meas_busy(meas_busy), .idle(idle), .wr_valid(wr_valid),
        .wr_cmd(wr_cmd), .wr_data(wr_data));
    i2c_master_model m (.scl(scl_w), .sda(sda_w), .scl_low(m_scl_low),
        .sda_low(m_sda_low));
    // ****
    // Clock, event counters and hang limit
    // ****
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = !mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        blen = (meas_start === 1'b1) ? 0 : blen + int'(meas_busy === 1'b1);
        n_start += int'(meas_start === 1'b1);
        n_wr += int'(wr_valid === 1'b1);
        n_drv += int'(scl_o !== 1'b0 || sda_o !== 1'b0);
        if (cyc == 40000)
        begin
            err_count++;
            final_report();
        end
    end
    // ****
    // Helpers and scenarios
    // ****
    task automatic chk(input logic ok, input string s);
        num_checks++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("BAD %0t %s", $time, s);
        end
    endtask : chk
    task automatic final_report();
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    function automatic logic [7:0] crc_ref(input logic [15:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        return c;
    endfunction : crc_ref
    task automatic wait_idle(output int n);
        n = 0;
        while (idle !== 1'b1 && n < 5000)
        begin
            @(posedge mclk);
            #1 n++;
        end
    endtask : wait_idle
    task automatic t_reset();
        int n;
        #1 chk(idle === 1'b0 && sda_oe === 1'b0, "reset outputs");
        rst = 1'b0;
        wait_idle(n);
        chk(n >= PU && n < PU + 8, "powerup wait");
    endtask : t_reset
    task automatic t_addr();
        logic a;
        for (int s = 1; s >= 0; s--)
        begin
            @(posedge mclk);
            #1 addr_sel = s[0];
            for (int h = 0; h < 2; h++)
            begin
                m.start();
                m.wbyte({h ? ADDR_HIGH : ADDR_LOW, 1'b0}, a);
                chk(a === (h == s), "address ack");
            end
            m.stop();
        end
    endtask : t_addr
    task automatic t_meas();
        logic [7:0] lsb [6] = '{CMD_S_HIGH, CMD_S_MED, CMD_S_LOW,
            CMD_N_HIGH, CMD_N_MED, CMD_N_LOW};
        logic [1:0] rep [3] = '{REP_HIGH, REP_MED, REP_LOW};
        int mc [3] = '{MH, MM, ML};
        logic a, b, c, d;
        logic [7:0] hi, lo, cr;
        int n, s0;
        for (int k = 0; k < 6; k++)
        begin
            @(posedge mclk);
            #1 temp_in = 16'h6a5c + 16'(k);
            s0 = n_start;
            m.start();
            m.wbyte(WH, a);
            m.wbyte(k < 3 ? CMD_MSB_STRETCH : CMD_MSB_NOSTRETCH, b);
            m.wbyte(lsb[k], c);
            chk(a & b & c, "command ack");
            chk(n_start == s0 + 1 && meas_rep === rep[k % 3], "start");
            m.start();
            m.wbyte(RH, d);
            chk(d === (k < 3), "read header");
            if (k >= 3)
            begin
                m.stop();
                wait_idle(n);
                m.start();
                m.wbyte(RH, d);
                chk(d === 1'b1, "read header data");
            end
            m.rbyte(1'b0, hi);
            m.rbyte(k == 5, lo);
            if (k < 5)
                m.rbyte(1'b1, cr);
            chk({hi, lo} === 16'h6a5c + 16'(k), "temperature");
            chk(k == 5 || cr === crc_ref({hi, lo}), "checksum");
            chk(blen >= mc[k % 3] - 2 && blen <= mc[k % 3], "length");
            m.stop();
            wait_idle(n);
            chk(idle === 1'b1, "idle");
        end
    endtask : t_meas
    task automatic t_data();
        logic a;
        int n, w0;
        for (int k = 0; k < 2; k++)
        begin
            w0 = n_wr;
            m.start();
            m.wbyte(WH, a);
            m.wbyte(CMD_MSB_NOSTRETCH, a);
            m.wbyte(CMD_N_LOW, a);
            m.wbyte(8'hbe, a);
            m.wbyte(8'hef, a);
            m.wbyte(crc_ref(16'hbeef) ^ 8'(k), a);
            chk(a === 1'b1, "crc byte ack");
            m.wbyte(8'h00, a);
            chk(a === 1'b0, "extra byte nack");
            m.stop();
            wait_idle(n);
            chk(n_wr == w0 + 1 - k, "data accept");
            chk(k == 1 || wr_data === 16'hbeef, "data word");
            chk(wr_cmd === {CMD_MSB_NOSTRETCH, CMD_N_LOW}, "cmd word");
        end
        m.start();
        m.wbyte(WH, a);
        m.wbyte(CMD_MSB_STRETCH, a);
        m.wbyte(8'h07, a);
        m.stop();
        chk(a === 1'b0, "bad command");
    endtask : t_data
    task automatic t_pins();
        int n;
        @(posedge mclk);
        #1 alert_cond = 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk(alert === 1'b1, "alert");
        pin_reset_low = 1'b0;
        alert_cond = 1'b0;
        repeat (130) @(posedge mclk);
        #1 chk(idle === 1'b0 && alert === 1'b0, "pin reset");
        pin_reset_low = 1'b1;
        wait_idle(n);
        chk(n >= PU && n < PU + 12, "pin reset wait");
    endtask : t_pins
    initial
    begin
        rst = 1'b1;
        addr_sel = 1'b0;
        pin_reset_low = 1'b1;
        alert_cond = 1'b0;
        temp_in = 16'h0000;
        repeat (12) @(posedge mclk);
        t_reset();
        t_addr();
        t_meas();
        t_data();
        t_pins();
        chk(n_drv == 0, "pins driven high");
        final_report();
    end
endmodule : test_temp_sensor_i2c_cmd_port
